// file: bus_cfg_map.svh
// Constants for the bus address and power-on request block
`ifndef BUS_CFG_MAP_SVH
`define BUS_CFG_MAP_SVH
`define ADDR_WIDTH 5
`define ADDR_MAX 5'h1E
`define ADDR_RESET 5'h00
`define PON_ENABLE_LEVEL 1'h0
`define REMOTE_START_LEVEL 1'h0
`define SETTLE_NS 40
`define SETTLE_CYCLES ((`SETTLE_NS + 4) / 5)
`define CMD_SEP 8'h3B
`define CHAR_V 8'h56
`define CHAR_I 8'h49
`define CHAR_S 8'h53
`define CHAR_E 8'h45
`define CHAR_T 8'h54
`define CASE_BIT 8'h20
`define VAL_WIDTH 16
`endif

// file: bus_cfg_pkg.sv
// Types for the bus address and power-on request block
package bus_cfg_pkg;
	typedef struct packed {
		logic [4:0] addr_switch;
		logic power_on_request_option;
		logic start_mode_select;
	} rear_config_switch_bank_t;
	typedef struct packed {
		logic [15:0] voltage;
		logic [15:0] current;
		logic voltage_load;
		logic current_load;
	} setpoint_t;
	typedef enum logic [2:0] {
		P_IDLE = 3'h0,
		P_S = 3'h1,
		P_E = 3'h3,
		P_T = 3'h2,
		P_VAL = 3'h6,
		P_SKIP = 3'h7
	} parse_state_t;
endpackage

// file: cmd_parser.sv
// Command string parser for setpoint commands
`timescale 1ns/1ps
`include "bus_cfg_map.svh"
module cmd_parser
	import bus_cfg_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic char_valid,
	input wire logic [7:0] char_data,
	output setpoint_t setpoints
);
	parse_state_t state;
	parse_state_t next_state;
	logic is_volt;
	logic next_is_volt;
	logic [15:0] acc;
	logic [15:0] next_acc;
	setpoint_t next_setpoints;
	logic [7:0] up;

	// Fold lower case onto upper case
	function automatic logic [7:0] to_upper(input logic [7:0] c);
		if (c >= 8'h61 && c <= 8'h7A)
			to_upper = c & ~`CASE_BIT;
		else
			to_upper = c;
	endfunction

	always_comb
	begin
		up = to_upper(char_data);
		next_state = state;
		next_is_volt = is_volt;
		next_acc = acc;
		next_setpoints = setpoints;
		next_setpoints.voltage_load = 1'b0;
		next_setpoints.current_load = 1'b0;
		if (char_valid)
		begin
			unique case (state)
				P_IDLE:
				begin
					next_acc = 16'h0000;
					if (up == `CHAR_V || up == `CHAR_I)
					begin
						next_is_volt = (up == `CHAR_V);
						next_state = P_S;
					end
					else if (up != `CMD_SEP)
						next_state = P_SKIP;
				end
				P_S:
					next_state = (up == `CHAR_S) ? P_E : P_SKIP;
				P_E:
					next_state = (up == `CHAR_E) ? P_T : P_SKIP;
				P_T:
					next_state = (up == `CHAR_T) ? P_VAL : P_SKIP;
				P_VAL:
				begin
					if (up >= 8'h30 && up <= 8'h39)
						next_acc = 16'((acc * 16'h000A) + {8'h00, up - 8'h30});
					else if (up == `CMD_SEP)
					begin
						next_state = P_IDLE;
						if (is_volt)
						begin
							next_setpoints.voltage = acc;
							next_setpoints.voltage_load = 1'b1;
						end
						else
						begin
							next_setpoints.current = acc;
							next_setpoints.current_load = 1'b1;
						end
					end
					else if (up != 8'h20)
						next_state = P_SKIP;
				end
				P_SKIP:
					if (up == `CMD_SEP)
						next_state = P_IDLE;
				default:
					next_state = P_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state <= P_IDLE;
			is_volt <= 1'b0;
			acc <= 16'h0000;
			setpoints <= '0;
		end
		else
		begin
			state <= next_state;
			is_volt <= next_is_volt;
			acc <= next_acc;
			setpoints <= next_setpoints;
		end
	end
endmodule

// file: bus_cfg_top.sv
// Bus address straps, power-on request and remote start for the supply
`timescale 1ns/1ps
`include "bus_cfg_map.svh"
module bus_cfg_top
	import bus_cfg_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input rear_config_switch_bank_t rear_config_switch_bank,
	input wire logic bus_addr_valid,
	input wire logic [4:0] bus_addr,
	input wire logic serial_poll,
	input wire logic char_valid,
	input wire logic [7:0] char_data,
	output logic [4:0] primary_address,
	output logic address_valid,
	output logic addressed,
	output logic service_request,
	output logic request_indicator,
	output logic remote_mode_indicator,
	output logic ready,
	output logic [15:0] voltage_setpoint,
	output logic [15:0] current_setpoint
);
	// =====================================
	// Power-on sampling
	logic [3:0] settle;
	logic [3:0] next_settle;
	logic [4:0] next_primary_address;
	logic next_address_valid;
	logic next_ready;
	logic sample;
	logic pon_enabled;
	logic next_service_request;
	logic next_remote_mode_indicator;
	logic next_addressed;
	logic [4:0] addr_bits;
	setpoint_t setpoints;
	logic char_ok;
	logic [15:0] next_voltage_setpoint;
	logic [15:0] next_current_setpoint;

	// Address from switches, bit0 is the lowest switch
	function automatic logic [4:0] switch_addr(input logic [4:0] sw);
		switch_addr = sw;
	endfunction

	always_comb
	begin
		next_settle = settle;
		sample = 1'b0;
		next_ready = ready;
		if (!ready)
		begin
			// Counter sized to hold the full settle count
			if (settle == 4'(`SETTLE_CYCLES))
			begin
				sample = 1'b1;
				next_ready = 1'b1;
			end
			else
				next_settle = settle + 4'h1;
		end
	end

	// =====================================
	// Strap capture and request
	always_comb
	begin
		addr_bits = switch_addr(rear_config_switch_bank.addr_switch);
		pon_enabled = (rear_config_switch_bank.power_on_request_option ==
			`PON_ENABLE_LEVEL);
		next_voltage_setpoint = voltage_setpoint;
		next_current_setpoint = current_setpoint;
		if (setpoints.voltage_load)
			next_voltage_setpoint = setpoints.voltage;
		if (setpoints.current_load)
			next_current_setpoint = setpoints.current;
		next_primary_address = primary_address;
		next_address_valid = address_valid;
		next_service_request = service_request;
		next_remote_mode_indicator = remote_mode_indicator;
		if (sample)
		begin
			next_primary_address = addr_bits;
			next_address_valid = (addr_bits <= `ADDR_MAX);
			next_remote_mode_indicator =
				(rear_config_switch_bank.start_mode_select ==
				`REMOTE_START_LEVEL);
		end
		if (serial_poll && ready)
			next_service_request = 1'b0;
		if (sample && pon_enabled)
			next_service_request = 1'b1;
		next_addressed = ready && address_valid && bus_addr_valid &&
			(bus_addr == primary_address);
	end

	always_ff @(posedge clk)
	begin
		// Reset doubles as brownout reinit, so straps are retaken
		if (srst)
		begin
			settle <= 4'h0;
			ready <= 1'b0;
			primary_address <= `ADDR_RESET;
			address_valid <= 1'b0;
			service_request <= 1'b0;
			request_indicator <= 1'b0;
			remote_mode_indicator <= 1'b0;
			addressed <= 1'b0;
			voltage_setpoint <= 16'h0000;
			current_setpoint <= 16'h0000;
		end
		else
		begin
			settle <= next_settle;
			ready <= next_ready;
			primary_address <= next_primary_address;
			address_valid <= next_address_valid;
			service_request <= next_service_request;
			request_indicator <= next_service_request;
			remote_mode_indicator <= next_remote_mode_indicator;
			addressed <= next_addressed;
			voltage_setpoint <= next_voltage_setpoint;
			current_setpoint <= next_current_setpoint;
		end
	end

	// Commands only while addressed
	assign char_ok = char_valid && addressed;

	cmd_parser u_parser (
		.clk(clk),
		.srst(srst),
		.char_valid(char_ok),
		.char_data(char_data),
		.setpoints(setpoints)
	);

	// =====================================
	// Checks
	property p_lamp_follows;
		@(posedge clk) disable iff (srst)
		request_indicator == service_request;
	endproperty
	a_lamp_follows: assert property (p_lamp_follows)
		else $error("request indicator differs from request");

	property p_poll_clears;
		@(posedge clk) disable iff (srst)
		(serial_poll && ready && !sample) |=> !service_request;
	endproperty
	a_poll_clears: assert property (p_poll_clears)
		else $error("serial poll did not clear request");

	property p_raise;
		@(posedge clk) disable iff (srst)
		(sample && !rear_config_switch_bank.power_on_request_option)
		|=> service_request;
	endproperty
	a_raise: assert property (p_raise)
		else $error("power-on request not raised");

	property p_disabled;
		@(posedge clk) disable iff (srst)
		(sample && rear_config_switch_bank.power_on_request_option)
		|=> $stable(service_request);
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("disabled option raised request");

	property p_addr;
		@(posedge clk) disable iff (srst)
		sample |=> primary_address ==
			$past(rear_config_switch_bank.addr_switch);
	endproperty
	a_addr: assert property (p_addr)
		else $error("address not taken from switches");

	property p_valid;
		@(posedge clk) disable iff (srst)
		address_valid |-> primary_address != 5'h1F;
	endproperty
	a_valid: assert property (p_valid)
		else $error("all-ones address marked valid");

	property p_match;
		@(posedge clk) disable iff (srst)
		addressed |-> $past(bus_addr) == primary_address;
	endproperty
	a_match: assert property (p_match)
		else $error("addressed on foreign address");

	property p_quiet;
		@(posedge clk) disable iff (srst)
		!ready |=> !addressed;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("responded before straps sampled");

	property p_remote;
		@(posedge clk) disable iff (srst)
		(sample && !rear_config_switch_bank.start_mode_select)
		|=> remote_mode_indicator;
	endproperty
	a_remote: assert property (p_remote)
		else $error("remote indicator not lit");
endmodule

// file: bus_ctrl_model.sv
// Bus controller model: address, serial poll and command bytes
`timescale 1ns/1ps
module bus_ctrl_model
(
	input wire logic clk,
	output logic bus_addr_valid,
	output logic [4:0] bus_addr,
	output logic serial_poll,
	output logic char_valid,
	output logic [7:0] char_data
);
	initial
	begin
		bus_addr_valid = 1'h0;
		bus_addr = 5'h00;
		serial_poll = 1'h0;
		char_valid = 1'h0;
		char_data = 8'h00;
	end
	// ==========================================
	// Access tasks
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	task automatic poll();
		step();
		serial_poll = 1'h1;
		step();
		serial_poll = 1'h0;
	endtask
	task automatic talk(input logic [4:0] a, input string s);
		step();
		bus_addr_valid = 1'h1;
		bus_addr = a;
		foreach (s[i])
		begin
			step();
			char_valid = 1'h1;
			char_data = s[i];
		end
		step();
		char_valid = 1'h0;
		// Released lines never keep the old byte
		char_data = ~char_data;
		step();
		step();
		bus_addr_valid = 1'h0;
		bus_addr = ~a;
	endtask
endmodule

// file: tb.sv
// Self-checking testbench for the bus address and power-on request block
`timescale 1ns/1ps
`include "bus_cfg_map.svh"
module tb
	import bus_cfg_pkg::*;
;
	logic clk = 1'h0;
	logic srst = 1'h1;
	rear_config_switch_bank_t sw = 7'h00;
	logic bus_addr_valid, serial_poll, char_valid;
	logic [4:0] bus_addr, primary_address;
	logic [7:0] char_data;
	logic address_valid, addressed, service_request, request_indicator;
	logic remote_mode_indicator, ready;
	logic [15:0] voltage_setpoint, current_setpoint;
	int err_count = 0;
	int checks = 0;
	// Address, option, start: 21/on/remote, 30/off/local, 0, all ones
	rear_config_switch_bank_t cases [4] = '{7'h54, 7'h7B, 7'h01, 7'h7D};
	always #2.5 clk = ~clk;
	bus_cfg_top uut (.clk, .srst, .rear_config_switch_bank(sw),
		.bus_addr_valid, .bus_addr, .serial_poll, .char_valid,
		.char_data, .primary_address, .address_valid, .addressed,
		.service_request, .request_indicator, .remote_mode_indicator,
		.ready, .voltage_setpoint, .current_setpoint);
	bus_ctrl_model ctrl (.clk, .bus_addr_valid, .bus_addr, .serial_poll,
		.char_valid, .char_data);
	// ==========================================
	// Check and report
	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ==========================================
	// Power-up with given straps
	task automatic power_up(input rear_config_switch_bank_t s);
		int n;
		@(posedge clk);
		#1;
		srst = 1'h1;
		sw = s;
		repeat (2) @(posedge clk);
		#1;
		srst = 1'h0;
		n = 0;
		while (ready !== 1'h1 && n < 20)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		check("settle", 16'(n), 16'(`SETTLE_CYCLES + 1));
		if (ready !== 1'h1)
			tally_and_finish();
		// Lamps land on the same edge as sampling and ready
		@(posedge clk);
		#1;
	endtask
	task automatic straps(input rear_config_switch_bank_t s);
		logic req;
		req = (s.power_on_request_option == `PON_ENABLE_LEVEL);
		check("ready", ready, 1'h1);
		check("primary_address", primary_address, s.addr_switch);
		check("sw_level", primary_address[0], s.addr_switch[0]);
		check("address_valid", address_valid,
			s.addr_switch <= `ADDR_MAX);
		check("service_request", service_request, req);
		check("req_option", service_request, req);
		check("request_indicator", request_indicator, req);
		check("remote_mode", remote_mode_indicator,
			s.start_mode_select == `REMOTE_START_LEVEL);
		check("start_mode", remote_mode_indicator,
			s.start_mode_select == 1'h0);
	endtask
	// ==========================================
	// Main sequence
	initial
	begin
		foreach (cases[i])
		begin
			power_up(cases[i]);
			straps(cases[i]);
			$display("test straps %0d done", i);
		end
		// All-ones address must not answer
		ctrl.talk(5'h1F, "vset9;");
		check("addressed", addressed, 1'h0);
		power_up(cases[0]);
		straps(cases[0]);
		// Straps moved after sampling must not be retaken
		sw = cases[1];
		ctrl.poll();
		check("service_request", service_request, 1'h0);
		check("request_indicator", request_indicator, 1'h0);
		$display("test poll done");
		ctrl.talk(5'h15, "VSET2;iset1;");
		check("addressed", addressed, 1'h1);
		repeat (3) @(posedge clk);
		#1;
		check("voltage_setpoint", voltage_setpoint, 16'h0002);
		check("current_setpoint", current_setpoint, 16'h0001);
		ctrl.talk(5'h14, "vset7;");
		check("addressed", addressed, 1'h0);
		repeat (3) @(posedge clk);
		#1;
		check("voltage_setpoint", voltage_setpoint, 16'h0002);
		check("primary_address", primary_address, 5'h15);
		$display("test commands done");
		tally_and_finish();
	end
endmodule
